// ### design/tep_pkg.sv
// constants, types and timing for the two-wire eeprom access block
//
// How it works
// - master sends 7-bit address, then direction
// - acknowledge accepted address byte on ninth bit
// - write protect high: no data ack, no change
// - byte write: one data byte, ack, stop
// - ack page bytes, bump low two address bits
// - stop starts the self-timed program cycle
// - busy programming: ignore bus, no response
// - busy: withhold first byte ack, then accept
// - byte read: ack, then drive stored byte
// - master ack: increment address, send next byte
// - read address wraps from top to zero
// - no ack on ninth read bit: go standby
// - every location reads all ones initially
`default_nettype none

package tep_pkg;

  // ************************************************************
  // memory geometry
  // ************************************************************
  localparam int          ADDR_W      = 7;      // byte address width
  localparam int          DATA_W      = 8;      // byte width
  localparam int          MEM_DEPTH   = 128;    // bytes in the array
  localparam int          PAGE_BYTES  = 4;      // bytes per row
  localparam int          IDX_W       = 2;      // byte index in a row
  localparam int          ROW_W       = 5;      // row_address_bits width
  localparam logic [7:0]  ERASED_BYTE = 8'hFF;  // blank cell content
  localparam logic        DIR_READ    = 1'b1;   // direction bit: read

  // ************************************************************
  // program timing
  // ************************************************************
  localparam int SYS_CLK_HZ    = 50_000_000;  // system clock rate
  localparam int WRITE_TIME_MS = 10;          // program_cycle_time
  localparam int PROG_CYCLES   = WRITE_TIME_MS * (SYS_CLK_HZ / 1000);

  // ************************************************************
  // state encodings
  // ************************************************************
  // link states, gray along idle-address-ack-data-ack
  typedef enum logic [2:0] {
    S_IDLE  = 3'h0,
    S_ADDR  = 3'h1,
    S_ACK_A = 3'h3,
    S_WDATA = 3'h2,
    S_ACK_W = 3'h6,
    S_RDATA = 3'h7,
    S_ACK_R = 3'h5
  } tep_link_state_t;

  // program sequencer states
  typedef enum logic {
    P_IDLE = 1'h0,
    P_RUN  = 1'h1
  } tep_prog_state_t;

endpackage

`default_nettype wire

// ### design/tep_sync.sv
// two-flop level synchroniser for signals entering a clock domain
`default_nettype none

module tep_sync #(
  parameter int W = 1                  // bits, each an independent level
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_q;                // first stage, read only by q
  logic [W-1:0] meta_d;
  logic [W-1:0] q_d;

  // ************************************************************
  // next values
  // ************************************************************
  always_comb begin
    meta_d = d;
    q_d    = meta_q;
  end

  // ************************************************************
  // two stages, cleared by reset
  // ************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= meta_d;
      q      <= q_d;
    end
  end

endmodule // tep_sync

`default_nettype wire

// ### design/tep_mem.sv
// byte array with a row-wide write port and an asynchronous read port
`default_nettype none

module tep_mem (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic [3:0]  wr_en,      // one enable per byte of the row
  input  wire logic [4:0]  wr_row,     // row_address_bits of the write
  input  wire logic [31:0] wr_data,    // byte e at bits 8e+7..8e
  input  wire logic [6:0]  rd_addr,    // read byte address
  output logic      [7:0]  rd_data     // content at rd_addr
);

  // the cell array
  logic [tep_pkg::DATA_W-1:0] mem_q [tep_pkg::MEM_DEPTH];

  // read is combinational; writes only happen while the link refuses
  // the bus, so the link never sees the array change under it
  assign rd_data = mem_q[rd_addr];

  // ************************************************************
  // erase on reset, then row writes from the program sequencer
  // ************************************************************
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < tep_pkg::MEM_DEPTH; i++) begin
        mem_q[i] <= tep_pkg::ERASED_BYTE;
      end
    end else begin
      for (int e = 0; e < tep_pkg::PAGE_BYTES; e++) begin
        if (wr_en[e]) begin
          mem_q[{wr_row, 2'(e)}] <= wr_data[e*8 +: 8];
        end
      end
    end
  end

endmodule // tep_mem

`default_nettype wire

// ### design/tep_top.sv
// two-wire eeprom access: link state machine, page latches, program timer
`default_nettype none

module tep_top #(
  parameter int PROG_CYCLES = tep_pkg::PROG_CYCLES  // program length
) (
  input  wire logic sys_clk,             // system clock, 50 MHz
  input  wire logic rst_n,               // async reset, active low
  input  wire logic scl_clk,             // serial clock from the master
  input  wire logic sda_i,               // serial data as seen on the wire
  input  wire logic write_protect_input, // high blocks data writes
  output logic      sda_o,               // always low: open drain
  output logic      sda_oe,              // high while pulling sda low
  output logic      busy                 // program cycle in progress
);

  // ************************************************************
  // declarations
  // ************************************************************
  tep_pkg::tep_link_state_t state_q, state_d;   // link state
  logic [2:0]  cnt_q, cnt_d;                    // bit within byte
  logic [7:0]  shift_q, shift_d;                // incoming bits
  logic [6:0]  addr_q, addr_d;                  // address counter
  logic        rw_q, rw_d;                      // direction bit
  logic        ack_ok_q, ack_ok_d;              // address byte accepted
  logic        wp_flag_q, wp_flag_d;            // protect seen at start or address
  logic [3:0][7:0] page_q, page_d;              // latched row bytes
  logic [3:0]  valid_q, valid_d;                // latched byte flags
  logic        start_seen_q, start_seen_d;      // last start handled
  logic        start_tgl_q, start_tgl_d;        // flips on each start
  logic        stop_tgl_q, stop_tgl_d;          // flips on each stop
  logic        start_pend;                      // start before this edge
  logic [7:0]  byte_in;                         // byte incl. current bit
  logic        oe_d;                            // next sda drive
  logic        sda_oe_q;                        // sda drive flop
  logic        wp_s;                            // protect, scl domain
  logic        busy_s;                          // busy, scl domain
  logic [7:0]  rd_data;                         // array read data
  tep_pkg::tep_prog_state_t prog_q, prog_d;     // program sequencer
  logic [31:0] prog_cnt_q, prog_cnt_d;          // program time counter
  logic        stop_s;                          // stop toggle, sys domain
  logic        stop_prev_q;                     // previous stop_s
  logic        stop_evt;                        // one-cycle stop event
  logic [3:0]  wr_en;                           // row write enables

  // open drain: only the enable moves
  assign sda_o  = 1'b0;
  assign sda_oe = sda_oe_q;
  assign busy   = (prog_q == tep_pkg::P_RUN);

  // ************************************************************
  // start and stop detection, clocked by sda edges
  // ************************************************************
  // a start or stop happens with scl high and no scl edge, so only
  // sda edges can see it; each is recorded as a toggle
  always_comb begin
    start_tgl_d = scl_clk ? ~start_tgl_q : start_tgl_q;
    stop_tgl_d  = scl_clk ? ~stop_tgl_q : stop_tgl_q;
  end

  // falling sda with scl high is a start
  always_ff @(negedge sda_i or negedge rst_n) begin
    if (!rst_n) begin
      start_tgl_q <= 1'b0;
    end else begin
      start_tgl_q <= start_tgl_d;
    end
  end

  // rising sda with scl high is a stop
  always_ff @(posedge sda_i or negedge rst_n) begin
    if (!rst_n) begin
      stop_tgl_q <= 1'b0;
    end else begin
      stop_tgl_q <= stop_tgl_d;
    end
  end

  // ************************************************************
  // crossings into the link domain
  // ************************************************************
  // start toggle settles while scl is high, before the next rise
  assign start_pend = (start_tgl_q != start_seen_q);

  tep_sync #(.W(2)) u_sync_link (
    .clk   (scl_clk),
    .rst_n (rst_n),
    .d     ({write_protect_input, busy}),
    .q     ({wp_s, busy_s})
  );

  // ************************************************************
  // link state machine, next values
  // ************************************************************
  always_comb begin
    state_d      = state_q;
    cnt_d        = cnt_q;
    shift_d      = shift_q;
    addr_d       = addr_q;
    rw_d         = rw_q;
    ack_ok_d     = ack_ok_q;
    wp_flag_d    = wp_flag_q;
    page_d       = page_q;
    valid_d      = valid_q;
    start_seen_d = start_seen_q;
    byte_in      = {shift_q[6:0], sda_i};
    if (start_pend) begin
      // first address bit, msb first; restart from any state
      state_d      = tep_pkg::S_ADDR;
      cnt_d        = 3'h1;
      shift_d      = {7'h00, sda_i};
      start_seen_d = start_tgl_q;
      wp_flag_d    = wp_s;
    end else begin
      unique case (state_q)
        tep_pkg::S_IDLE: begin
          // standby: wait for the next start
        end
        tep_pkg::S_ADDR: begin
          shift_d   = byte_in;
          cnt_d     = cnt_q + 3'h1;
          wp_flag_d = wp_flag_q | wp_s;
          if (cnt_q == 3'h7) begin
            state_d  = tep_pkg::S_ACK_A;
            ack_ok_d = !busy_s;
            // while busy the latches and address stay untouched
            if (!busy_s) begin
              addr_d  = byte_in[7:1];
              rw_d    = byte_in[0];
              valid_d = 4'h0;
            end
          end
        end
        tep_pkg::S_ACK_A: begin
          cnt_d = 3'h0;
          if (!ack_ok_q) begin
            state_d = tep_pkg::S_IDLE;
          end else if (rw_q == tep_pkg::DIR_READ) begin
            state_d = tep_pkg::S_RDATA;
          end else begin
            state_d = tep_pkg::S_WDATA;
          end
        end
        tep_pkg::S_WDATA: begin
          shift_d = byte_in;
          cnt_d   = cnt_q + 3'h1;
          if (cnt_q == 3'h7) begin
            state_d = tep_pkg::S_ACK_W;
            // protected frames latch nothing, so stop programs nothing
            if (!wp_flag_q) begin
              page_d[addr_q[1:0]]  = byte_in;
              valid_d[addr_q[1:0]] = 1'b1;
            end
          end
        end
        tep_pkg::S_ACK_W: begin
          // row stays fixed; a fifth byte overwrites the first
          addr_d  = {addr_q[6:2], addr_q[1:0] + 2'h1};
          cnt_d   = 3'h0;
          state_d = tep_pkg::S_WDATA;
        end
        tep_pkg::S_RDATA: begin
          cnt_d = cnt_q + 3'h1;
          if (cnt_q == 3'h7) begin
            state_d = tep_pkg::S_ACK_R;
          end
        end
        tep_pkg::S_ACK_R: begin
          cnt_d = 3'h0;
          if (!sda_i) begin
            addr_d  = addr_q + 7'h01;
            state_d = tep_pkg::S_RDATA;
          end else begin
            state_d = tep_pkg::S_IDLE;
          end
        end
        default: begin
          state_d = tep_pkg::S_IDLE;   // unused code
        end
      endcase
    end
  end

  // ************************************************************
  // link state machine, registers on rising scl
  // ************************************************************
  always_ff @(posedge scl_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q      <= tep_pkg::S_IDLE;
      cnt_q        <= 3'h0;
      shift_q      <= 8'h00;
      addr_q       <= 7'h00;
      rw_q         <= 1'b0;
      ack_ok_q     <= 1'b0;
      wp_flag_q    <= 1'b0;
      page_q       <= 32'h0000_0000;
      valid_q      <= 4'h0;
      start_seen_q <= 1'b0;
    end else begin
      state_q      <= state_d;
      cnt_q        <= cnt_d;
      shift_q      <= shift_d;
      addr_q       <= addr_d;
      rw_q         <= rw_d;
      ack_ok_q     <= ack_ok_d;
      wp_flag_q    <= wp_flag_d;
      page_q       <= page_d;
      valid_q      <= valid_d;
      start_seen_q <= start_seen_d;
    end
  end

  // ************************************************************
  // sda drive, changed on falling scl
  // ************************************************************
  always_comb begin
    unique case (state_q)
      tep_pkg::S_ACK_A: oe_d = ack_ok_q;
      tep_pkg::S_ACK_W: oe_d = !wp_flag_q;
      tep_pkg::S_RDATA: oe_d = !rd_data[~cnt_q];
      default:          oe_d = 1'b0;
    endcase
  end

  always_ff @(negedge scl_clk or negedge rst_n) begin
    if (!rst_n) begin
      sda_oe_q <= 1'b0;
    end else begin
      sda_oe_q <= oe_d;
    end
  end

  // ************************************************************
  // program sequencer in the system domain
  // ************************************************************
  // the stop toggle crosses as a level; its change is the event
  tep_sync #(.W(1)) u_sync_stop (
    .clk   (sys_clk),
    .rst_n (rst_n),
    .d     (stop_tgl_q),
    .q     (stop_s)
  );

  assign stop_evt = stop_s ^ stop_prev_q;

  // latches and row are quasi-static here: the link nacks while busy
  always_comb begin
    prog_d     = prog_q;
    prog_cnt_d = prog_cnt_q;
    wr_en      = 4'h0;
    unique case (prog_q)
      tep_pkg::P_IDLE: begin
        if (stop_evt && (valid_q != 4'h0)) begin
          prog_d     = tep_pkg::P_RUN;
          prog_cnt_d = 32'h0000_0000;
        end
      end
      tep_pkg::P_RUN: begin
        if (prog_cnt_q == 32'(PROG_CYCLES - 1)) begin
          wr_en  = valid_q;
          prog_d = tep_pkg::P_IDLE;
        end else begin
          prog_cnt_d = prog_cnt_q + 32'h0000_0001;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prog_q      <= tep_pkg::P_IDLE;
      prog_cnt_q  <= 32'h0000_0000;
      stop_prev_q <= 1'b0;
    end else begin
      prog_q      <= prog_d;
      prog_cnt_q  <= prog_cnt_d;
      stop_prev_q <= stop_s;
    end
  end

  // ************************************************************
  // cell array
  // ************************************************************
  tep_mem u_mem (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .wr_en   (wr_en),
    .wr_row  (addr_q[6:2]),
    .wr_data (page_q),
    .rd_addr (addr_q),
    .rd_data (rd_data)
  );

  // ************************************************************
  // checks
  // ************************************************************
  chk_addr_ack: assert property (@(posedge scl_clk) disable iff (!rst_n)
    (state_q == tep_pkg::S_ACK_A && ack_ok_q) |-> sda_oe_q)
    else $error("accepted address byte not acknowledged");
  chk_busy_nack: assert property (@(posedge scl_clk) disable iff (!rst_n)
    (state_q == tep_pkg::S_ACK_A && !ack_ok_q) |-> !sda_oe_q ##1 !sda_oe_q)
    else $error("address acknowledged while busy");
  chk_wp_nack: assert property (@(posedge scl_clk) disable iff (!rst_n)
    (state_q == tep_pkg::S_ACK_W && wp_flag_q) |-> !sda_oe_q && valid_q == $past(valid_q))
    else $error("protected data byte acknowledged or latched");
  chk_row_wrap: assert property (@(posedge scl_clk) disable iff (!rst_n)
    (state_q == tep_pkg::S_ACK_W && !start_pend) |=>
      addr_q[6:2] == $past(addr_q[6:2]) && addr_q[1:0] == $past(addr_q[1:0]) + 2'h1)
    else $error("page address step wrong");
  chk_read_bit: assert property (@(posedge scl_clk) disable iff (!rst_n)
    (state_q == tep_pkg::S_RDATA) |-> sda_oe_q == !rd_data[~cnt_q])
    else $error("read data bit wrong");
  chk_read_inc: assert property (@(posedge scl_clk) disable iff (!rst_n)
    (state_q == tep_pkg::S_ACK_R && !sda_i && !start_pend) |=> addr_q == $past(addr_q) + 7'h01)
    else $error("read address not advanced");
  chk_nack_idle: assert property (@(posedge scl_clk) disable iff (!rst_n)
    (state_q == tep_pkg::S_ACK_R && sda_i && !start_pend) |=> state_q == tep_pkg::S_IDLE ##1 !sda_oe_q)
    else $error("no standby after master nack");
  chk_prog_start: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (stop_evt && valid_q != 4'h0 && !busy) |=> busy)
    else $error("stop did not start program cycle");
  chk_prog_len: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $fell(busy) |-> $past(prog_cnt_q) == 32'(PROG_CYCLES - 1) && $past(wr_en) == $past(valid_q))
    else $error("program cycle length or write wrong");
  cov_page_full: cover property (@(posedge scl_clk) disable iff (!rst_n)
    state_q == tep_pkg::S_ACK_W && valid_q == 4'hF);
  cov_read_wrap: cover property (@(posedge scl_clk) disable iff (!rst_n)
    state_q == tep_pkg::S_ACK_R && addr_q == 7'h7F && !sda_i);
  cov_poll_nack: cover property (@(posedge scl_clk) disable iff (!rst_n)
    state_q == tep_pkg::S_ACK_A && !ack_ok_q);
  cov_prog_done: cover property (@(posedge sys_clk) disable iff (!rst_n) $fell(busy));

endmodule // tep_top

`default_nettype wire

// ### verif/tep_master_model.sv
// two-wire bus master model: drives the serial clock, pulls sda, resolves the wire
`default_nettype none

module tep_master_model (
  output logic      scl_clk,  // serial clock, stands high outside frames
  input  wire logic dev_oe,   // device pulls sda low
  output logic      sda_i     // resolved wire level
);
  timeunit 1ns;
  timeprecision 1ps;

  logic m_oe = 1'b0;          // master pulls sda low
  initial scl_clk = 1'b1;     // idle high, no free-running clock

  // ************************************************************
  // wire resolution
  // ************************************************************
  // pull-up: a released wire reads high, never the last value
  assign sda_i = ~(m_oe | dev_oe);

  // ************************************************************
  // bit-level tasks, 12 ns per bit
  // ************************************************************
  // data moves 1 ns after scl falls so no false start or stop is seen
  task automatic bit_xfer(input logic b, output logic s);
    #1 m_oe = ~b;
    #5 scl_clk = 1'b1;
    s = sda_i;
    #6 scl_clk = 1'b0;
  endtask

  // start or repeated start: sda falls while scl high
  task automatic start_cond();
    #1 m_oe = 1'b0;
    #5 scl_clk = 1'b1;
    #6 m_oe = 1'b1;
    #6 scl_clk = 1'b0;
  endtask

  // stop: sda rises while scl high, clock then stands still
  task automatic stop_cond();
    #1 m_oe = 1'b1;
    #5 scl_clk = 1'b1;
    #6 m_oe = 1'b0;
    #6;
  endtask

  // eight bits msb first, then the acknowledge bit time
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(b[i], s);
    end
    bit_xfer(1'b1, s);
    ack = ~s;
  endtask

  // receive a byte; mack low leaves sda high on the ninth bit
  task automatic read_byte(input logic mack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(1'b1, s);
      d[i] = s;
    end
    bit_xfer(~mack, s);
  endtask
endmodule // tep_master_model

`default_nettype wire

// ### verif/tb_tep_top.sv
// self-checking testbench for the two-wire eeprom access block
`default_nettype none

module tb_tep_top;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int PC = 20;                 // short program time
  logic sys_clk             = 1'b1;        // 50 MHz, first edge falls
  logic rst_n               = 1'b1;        // async reset, pulled low at the first falling edge
  logic write_protect_input = 1'b0;        // write blocking level
  logic scl_clk;                           // from the master model
  logic sda_i;                             // resolved wire
  logic sda_o;                             // open drain value
  logic sda_oe;                            // device pull enable
  logic busy;                              // program in progress
  int   error_cnt           = 0;           // mismatches
  int   compares            = 0;           // comparisons made

  tep_top #(.PROG_CYCLES(PC)) uut (
    .sys_clk             (sys_clk),
    .rst_n               (rst_n),
    .scl_clk             (scl_clk),
    .sda_i               (sda_i),
    .write_protect_input (write_protect_input),
    .sda_o               (sda_o),
    .sda_oe              (sda_oe),
    .busy                (busy)
  );

  tep_master_model bus (
    .scl_clk (scl_clk),
    .dev_oe  (sda_oe),
    .sda_i   (sda_i)
  );

  // system clock, unrelated to the 12 ns serial bit rate
  always #10 sys_clk = ~sys_clk;

  // ************************************************************
  // shared helpers
  // ************************************************************
  task automatic end_sim();
    $display("compares=%0d error_cnt=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // bounded wait for the busy level, a hang ends the run
  task automatic wait_busy(input logic lvl, input int lim);
    int n;
    n = 0;
    while (busy !== lvl && n < lim) begin
      @(negedge sys_clk);
      n++;
    end
    check({7'h00, busy}, {7'h00, lvl});
    if (busy !== lvl) begin
      end_sim();
    end
  endtask

  // write frame; dack is the expected acknowledge on data bytes
  task automatic write_bytes(input logic [6:0] a, input logic [7:0] d[$], input logic dack);
    logic ack;
    bus.start_cond();
    bus.send_byte({a, 1'b0}, ack);
    check({7'h00, ack}, 8'h01);
    foreach (d[i]) begin
      bus.send_byte(d[i], ack);
      check({7'h00, ack}, {7'h00, dack});
    end
    bus.stop_cond();
  endtask

  // read frame: master acks all but the last byte, then stops
  task automatic read_bytes(input logic [6:0] a, input logic [7:0] e[$]);
    logic       ack;
    logic [7:0] d;
    bus.start_cond();
    bus.send_byte({a, 1'b1}, ack);
    check({7'h00, ack}, 8'h01);
    foreach (e[i]) begin
      bus.read_byte(i < e.size() - 1, d);
      check(d, e[i]);
    end
    bus.stop_cond();
  endtask

  // poll while programming: refused first, then acked and read back
  task automatic poll_read(input logic [6:0] a, input logic [7:0] e);
    logic ack;
    wait_busy(1'b1, 50);
    bus.start_cond();
    bus.send_byte({a, 1'b1}, ack);
    check({7'h00, ack}, 8'h00);
    wait_busy(1'b0, PC + 50);
    read_bytes(a, {e});
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_blank();
    read_bytes(7'h05, {8'hFF});
    check({7'h00, sda_o}, 8'h00);
    $display("t_blank done");
  endtask

  task automatic t_byte_write();
    write_bytes(7'h00, {8'hA5}, 1'b1);
    poll_read(7'h00, 8'hA5);
    $display("t_byte_write done");
  endtask

  // four bytes from index 2: the row index rolls 3 -> 0, nothing is overwritten
  task automatic t_page_write();
    write_bytes(7'h22, {8'h11, 8'h22, 8'h33, 8'h44}, 1'b1);
    poll_read(7'h23, 8'h22);
    read_bytes(7'h20, {8'h33, 8'h44, 8'h11, 8'h22});
    $display("t_page_write done");
  endtask

  task automatic t_protect();
    @(negedge sys_clk);
    write_protect_input = 1'b1;
    write_bytes(7'h30, {8'h5A}, 1'b0);
    @(negedge sys_clk);
    write_protect_input = 1'b0;
    repeat (20) @(negedge sys_clk);
    check({7'h00, busy}, 8'h00);
    read_bytes(7'h30, {8'hFF});
    $display("t_protect done");
  endtask

  // top address rolls to zero; a nack silences the device
  task automatic t_wrap_nack();
    logic       ack;
    logic [7:0] d;
    read_bytes(7'h7F, {8'hFF, 8'hA5, 8'hFF});
    bus.start_cond();
    bus.send_byte({7'h21, 1'b1}, ack);
    check({7'h00, ack}, 8'h01);
    bus.read_byte(1'b0, d);
    check(d, 8'h44);
    bus.read_byte(1'b0, d);
    check(d, 8'hFF);
    bus.stop_cond();
    $display("t_wrap_nack done");
  endtask

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    // a real falling reset edge, so flops clocked by scl and sda clear too
    @(negedge sys_clk);
    rst_n = 1'b0;
    repeat (4) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (2) @(negedge sys_clk);
    t_blank();
    t_byte_write();
    t_page_write();
    t_protect();
    t_wrap_nack();
    end_sim();
  end
endmodule // tb_tep_top

`default_nettype wire
